// [hdl/chgirq_pkg.sv]
// chgirq_pkg: constants, types and helpers shared by the charger interrupt/status block.
// assumes a single 20 MHz system clock and byte-wide register reads from the serial interface.
package chgirq_pkg;

	// register offsets on the serial register interface
	localparam logic [7:0] CHGIRQ_ADDR_FLAGS  = 8'h01;
	localparam logic [7:0] CHGIRQ_ADDR_STATUS = 8'h02;

	// charger_interrupt_flags bit positions
	localparam int CHGIRQ_FLG_SYS_CFG   = 6;
	localparam int CHGIRQ_FLG_SYS_MIN   = 5;
	localparam int CHGIRQ_FLG_INPUT_LP  = 4;
	localparam int CHGIRQ_FLG_DIE_TEMP  = 3;
	localparam int CHGIRQ_FLG_IN_STATE  = 2;
	localparam int CHGIRQ_FLG_CHG_STATE = 1;
	localparam int CHGIRQ_FLG_ZONE      = 0;
	localparam int CHGIRQ_FLG_W         = 7;

	// charger_loop_status bit positions
	localparam int CHGIRQ_ST_VIN_LOOP = 6;
	localparam int CHGIRQ_ST_IIN_LOOP = 5;
	localparam int CHGIRQ_ST_SYS_LOOP = 4;
	localparam int CHGIRQ_ST_TJ_LOOP  = 3;

	// reset values
	localparam logic [6:0] CHGIRQ_FLAGS_RST  = 7'h00;
	localparam logic [7:0] CHGIRQ_STATUS_RST = 8'h00;
	localparam logic [7:0] CHGIRQ_RDATA_RST  = 8'h00;

	// voltage margin that the system target keeps above the charge target
	localparam int CHGIRQ_MARGIN_MV = 200;

	// battery temperature zone codes
	typedef enum logic [2:0] {
		CHGIRQ_ZONE_OFF    = 3'h0,
		CHGIRQ_ZONE_COLD   = 3'h1,
		CHGIRQ_ZONE_COOL   = 3'h2,
		CHGIRQ_ZONE_WARM   = 3'h3,
		CHGIRQ_ZONE_HOT    = 3'h4,
		CHGIRQ_ZONE_NORMAL = 3'h5
	} chgirq_zone_t;

	// input supply state codes
	typedef enum logic [1:0] {
		CHGIRQ_IN_LOW      = 2'h0,
		CHGIRQ_IN_OVERVOLT = 2'h1,
		CHGIRQ_IN_DEBOUNCE = 2'h2,
		CHGIRQ_IN_VALID    = 2'h3
	} chgirq_in_state_t;

	// linear code to millivolt conversion, used for both charge and system targets
	function automatic int chgirq_code_mv(input int code, input int base_mv, input int step_mv);
		return base_mv + code * step_mv;
	endfunction

	// requested charge code, capped at the largest code that keeps the margin below a given system target
	function automatic logic [5:0] chgirq_clamp_cv(input logic [5:0] req, input int sys_mv,
		input int base_mv, input int step_mv);
		int lim;
		int top;
		lim = sys_mv - CHGIRQ_MARGIN_MV;
		if (chgirq_code_mv(int'(req), base_mv, step_mv) <= lim)
			return req;
		if (lim < base_mv)
			return 6'h00;
		top = (lim - base_mv) / step_mv;
		return top[5:0];
	endfunction

endpackage

// [hdl/chgirq_change_det.sv]
// chgirq_change_det: flags any change of a multi-bit status value.
// assumes the value is already registered in the system clock domain.
`timescale 1ns/1ps

module chgirq_change_det
	import chgirq_pkg::*;
#(
	parameter int W = 1
)
(
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// watched value and change pulse
	input  wire logic [W-1:0] value,
	output logic              changed_r
);

	logic [W-1:0] prev_r;

	// previous copy resets to the same value the status resets to, so reset itself is no event
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			prev_r <= '0;
		else
			prev_r <= value;
	end

	// one-cycle pulse for a change in either direction
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			changed_r <= 1'b0;
		else
			changed_r <= (value != prev_r);
	end

endmodule // chgirq_change_det

// [hdl/chgirq_top.sv]
// chgirq_top: charger interrupt flags, loop/temperature status and charge-voltage clamp.
// assumes the serial register interface delivers one-cycle read strobes on clk_sys, and
// that analog status inputs are already synchronous to clk_sys.
`timescale 1ns/1ps

module chgirq_top
	import chgirq_pkg::*;
#(
	parameter int CV_BASE_MV  = 3600,
	parameter int CV_STEP_MV  = 25,
	parameter int SYS_BASE_MV = 4100,
	parameter int SYS_STEP_MV = 25
)
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// charger input ok; low clears the status domain
	input  wire logic       charger_input_ok,
	// register read port
	input  wire logic       rd_en,
	input  wire logic [7:0] rd_addr,
	output logic [7:0]      rd_data_r,
	output logic            rd_valid_r,
	// live regulation-loop and charger state
	input  wire logic       input_voltage_loop_active,
	input  wire logic       input_current_loop_active,
	input  wire logic       system_voltage_loop_active,
	input  wire logic       die_temp_loop_active,
	input  wire logic [2:0] battery_temp_zone,
	input  wire logic [1:0] input_supply_state,
	input  wire logic [3:0] charger_state_code,
	// charge-voltage configuration
	input  wire logic [5:0] cv_code_req,
	input  wire logic [5:0] temp_cv_code_req,
	input  wire logic [4:0] sys_reg_code,
	output logic [5:0]      charge_voltage_setting_r,
	output logic [5:0]      temp_modified_charge_voltage_setting_r,
	output logic            zone_valid_r
);

	// status-domain registers
	logic                   vin_loop_r;
	logic                   iin_loop_r;
	logic                   sys_loop_r;
	logic                   tj_loop_r;
	logic [2:0]             zone_r;
	logic [1:0]             in_state_r;
	logic [3:0]             chg_state_r;
	// change pulses
	logic                   sys_loop_chg;
	logic                   in_loop_chg;
	logic                   tj_loop_chg;
	logic                   in_state_chg;
	logic                   chg_state_chg;
	logic                   zone_chg;
	// clamp
	logic [5:0]             cv_eff;
	logic [5:0]             tcv_eff;
	logic                   forced_now;
	logic                   forced_r;
	logic                   cfg_err_evt;
	int                     sys_mv;
	// flags
	logic [CHGIRQ_FLG_W-1:0] flags_r;
	logic [CHGIRQ_FLG_W-1:0] flags_nxt;
	logic [CHGIRQ_FLG_W-1:0] flag_set;
	logic                    flag_rd;
	logic [7:0]              status_word;

	// status follows the analog loops; losing the charger input returns it to reset values
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			vin_loop_r  <= 1'b0;
			iin_loop_r  <= 1'b0;
			sys_loop_r  <= 1'b0;
			tj_loop_r   <= 1'b0;
			zone_r      <= CHGIRQ_ZONE_OFF;
			in_state_r  <= CHGIRQ_IN_LOW;
			chg_state_r <= 4'h0;
		end
		else if (!charger_input_ok)
		begin
			vin_loop_r  <= 1'b0;
			iin_loop_r  <= 1'b0;
			sys_loop_r  <= 1'b0;
			tj_loop_r   <= 1'b0;
			zone_r      <= CHGIRQ_ZONE_OFF;
			in_state_r  <= CHGIRQ_IN_LOW;
			chg_state_r <= 4'h0;
		end
		else
		begin
			vin_loop_r  <= input_voltage_loop_active;
			iin_loop_r  <= input_current_loop_active;
			sys_loop_r  <= system_voltage_loop_active;
			tj_loop_r   <= die_temp_loop_active;
			zone_r      <= battery_temp_zone;
			in_state_r  <= input_supply_state;
			chg_state_r <= charger_state_code;
		end
	end

	// zone is only meaningful to the host while the supply is valid
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			zone_valid_r <= 1'b0;
		else
			zone_valid_r <= (in_state_r == CHGIRQ_IN_VALID);
	end

	// change detectors, one per status flag source; the configuration flag has none
	chgirq_change_det #(.W(1)) u_sys_loop (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.value     (sys_loop_r),
		.changed_r (sys_loop_chg)
	);
	chgirq_change_det #(.W(2)) u_in_loop (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.value     ({vin_loop_r, iin_loop_r}),
		.changed_r (in_loop_chg)
	);
	chgirq_change_det #(.W(1)) u_tj_loop (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.value     (tj_loop_r),
		.changed_r (tj_loop_chg)
	);
	chgirq_change_det #(.W(2)) u_in_state (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.value     (in_state_r),
		.changed_r (in_state_chg)
	);
	chgirq_change_det #(.W(4)) u_chg_state (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.value     (chg_state_r),
		.changed_r (chg_state_chg)
	);
	chgirq_change_det #(.W(3)) u_zone (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.value     (zone_r),
		.changed_r (zone_chg)
	);

	// clamp both charge targets against the system target minus the margin
	always_comb
	begin
		sys_mv     = chgirq_code_mv(int'(sys_reg_code), SYS_BASE_MV, SYS_STEP_MV);
		cv_eff     = chgirq_clamp_cv(cv_code_req, sys_mv, CV_BASE_MV, CV_STEP_MV);
		tcv_eff    = chgirq_clamp_cv(temp_cv_code_req, sys_mv, CV_BASE_MV, CV_STEP_MV);
		forced_now = (cv_eff != cv_code_req) || (tcv_eff != temp_cv_code_req);
	end

	// effective settings are registered so the charger never sees a glitching code
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			charge_voltage_setting_r               <= 6'h00;
			temp_modified_charge_voltage_setting_r <= 6'h00;
			forced_r                               <= 1'b0;
		end
		else
		begin
			charge_voltage_setting_r               <= cv_eff;
			temp_modified_charge_voltage_setting_r <= tcv_eff;
			forced_r                               <= forced_now;
		end
	end

	// a clamp that newly takes hold is the configuration error event
	assign cfg_err_evt = forced_now && !forced_r;

	// gather the flag set terms
	always_comb
	begin
		flag_set                       = '0;
		flag_set[CHGIRQ_FLG_SYS_CFG]   = cfg_err_evt;
		flag_set[CHGIRQ_FLG_SYS_MIN]   = sys_loop_chg;
		flag_set[CHGIRQ_FLG_INPUT_LP]  = in_loop_chg;
		flag_set[CHGIRQ_FLG_DIE_TEMP]  = tj_loop_chg;
		flag_set[CHGIRQ_FLG_IN_STATE]  = in_state_chg;
		flag_set[CHGIRQ_FLG_CHG_STATE] = chg_state_chg;
		flag_set[CHGIRQ_FLG_ZONE]      = zone_chg;
	end

	// a read clears every flag, but a set in the same cycle wins so no event is lost
	assign flag_rd   = rd_en && (rd_addr == CHGIRQ_ADDR_FLAGS);
	assign flags_nxt = (flag_rd ? CHGIRQ_FLAGS_RST : flags_r) | flag_set;

	// flags belong to the system reset domain only, not the charger input domain
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			flags_r <= CHGIRQ_FLAGS_RST;
		else
			flags_r <= flags_nxt;
	end

	// assembled status byte; top bit is reserved
	assign status_word = {1'b0, vin_loop_r, iin_loop_r, sys_loop_r, tj_loop_r, zone_r};

	// read data is the value before the clearing read takes effect
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rd_data_r  <= CHGIRQ_RDATA_RST;
			rd_valid_r <= 1'b0;
		end
		else
		begin
			rd_valid_r <= rd_en;
			if (!rd_en)
				rd_data_r <= rd_data_r;
			else if (rd_addr == CHGIRQ_ADDR_FLAGS)
				rd_data_r <= {1'b0, flags_r};
			else if (rd_addr == CHGIRQ_ADDR_STATUS)
				rd_data_r <= status_word;
			else
				rd_data_r <= CHGIRQ_RDATA_RST;
		end
	end

	// helper: cycle-delayed charge millivolts for the margin check
	int cv_mv_chk;
	int tcv_mv_chk;
	assign cv_mv_chk  = chgirq_code_mv(int'(charge_voltage_setting_r), CV_BASE_MV, CV_STEP_MV);
	assign tcv_mv_chk = chgirq_code_mv(int'(temp_modified_charge_voltage_setting_r),
		CV_BASE_MV, CV_STEP_MV);

	// a clearing read with no new event empties the register
	property p_read_clears;
		@(posedge clk_sys) disable iff (rst)
		(flag_rd && flag_set == '0) |=> (flags_r == '0);
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("flags not cleared by read");

	// without a read a set flag stays set
	property p_flag_holds;
		@(posedge clk_sys) disable iff (rst)
		!flag_rd |=> ((flags_r & $past(flags_r)) == $past(flags_r));
	endproperty
	a_flag_holds: assert property (p_flag_holds)
		else $error("flag lost without a read");

	// registered settings keep the margin whenever they are not already at the floor
	property p_margin;
		@(posedge clk_sys) disable iff (rst)
		(charge_voltage_setting_r == 6'h00 || cv_mv_chk + CHGIRQ_MARGIN_MV <= $past(sys_mv))
		&& (temp_modified_charge_voltage_setting_r == 6'h00
		|| tcv_mv_chk + CHGIRQ_MARGIN_MV <= $past(sys_mv));
	endproperty
	a_margin: assert property (p_margin)
		else $error("charge voltage violates margin");

	// newly forced clamp raises the configuration flag next edge
	property p_cfg_err;
		@(posedge clk_sys) disable iff (rst)
		(forced_now && !forced_r) |=> flags_r[CHGIRQ_FLG_SYS_CFG];
	endproperty
	a_cfg_err: assert property (p_cfg_err)
		else $error("config error flag not set");

	// system loop status change shows two edges later
	property p_sys_loop;
		@(posedge clk_sys) disable iff (rst)
		$changed(sys_loop_r) |-> ##2 flags_r[CHGIRQ_FLG_SYS_MIN];
	endproperty
	a_sys_loop: assert property (p_sys_loop)
		else $error("system loop flag missed");

	// input loops change shows two edges later
	property p_in_loop;
		@(posedge clk_sys) disable iff (rst)
		($changed(vin_loop_r) || $changed(iin_loop_r)) |-> ##2 flags_r[CHGIRQ_FLG_INPUT_LP];
	endproperty
	a_in_loop: assert property (p_in_loop)
		else $error("input loop flag missed");

	// die temperature loop change
	property p_tj_loop;
		@(posedge clk_sys) disable iff (rst)
		$changed(tj_loop_r) |-> ##2 flags_r[CHGIRQ_FLG_DIE_TEMP];
	endproperty
	a_tj_loop: assert property (p_tj_loop)
		else $error("die temperature flag missed");

	// supply state, charger state and zone changes, each on its own flag
	property p_in_state;
		@(posedge clk_sys) disable iff (rst)
		$changed(in_state_r) |-> ##2 flags_r[CHGIRQ_FLG_IN_STATE];
	endproperty
	a_in_state: assert property (p_in_state)
		else $error("input state flag missed");

	property p_chg_state;
		@(posedge clk_sys) disable iff (rst)
		$changed(chg_state_r) |-> ##2 flags_r[CHGIRQ_FLG_CHG_STATE];
	endproperty
	a_chg_state: assert property (p_chg_state)
		else $error("charger state flag missed");

	property p_zone;
		@(posedge clk_sys) disable iff (rst)
		$changed(zone_r) |-> ##2 flags_r[CHGIRQ_FLG_ZONE];
	endproperty
	a_zone: assert property (p_zone)
		else $error("zone flag missed");

	// reserved top bit never reads one
	property p_top_zero;
		@(posedge clk_sys) disable iff (rst)
		rd_valid_r |-> !rd_data_r[7];
	endproperty
	a_top_zero: assert property (p_top_zero)
		else $error("reserved bit read as one");

	// status read returns the engaged loop bits of the cycle before
	property p_status_read;
		@(posedge clk_sys) disable iff (rst)
		(rd_en && rd_addr == CHGIRQ_ADDR_STATUS) |=>
			(rd_data_r[6:3] == $past(status_word[6:3]));
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read mismatch");

	// an event during the clearing read survives it
	property p_set_wins;
		@(posedge clk_sys) disable iff (rst)
		(flag_rd && flag_set != '0) |=> ((flags_r & $past(flag_set)) == $past(flag_set));
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("event lost during clearing read");

	// losing the charger input returns status to zero
	property p_input_loss;
		@(posedge clk_sys) disable iff (rst)
		!charger_input_ok |=> (status_word == CHGIRQ_STATUS_RST);
	endproperty
	a_input_loss: assert property (p_input_loss)
		else $error("status not cleared on input loss");

endmodule // chgirq_top

// [verif/chgirq_host_model.sv]
// chgirq_host_model: host side of the register read port, issuing single byte reads.
// assumes reads launch on falling edges of clk_sys and are answered on the same rising edge that takes them.
`timescale 1ns/1ps

module chgirq_host_model
(
	// clock
	input  wire logic       clk_sys,
	// read request
	output logic            rd_en,
	output logic [7:0]      rd_addr,
	// read answer and zone qualifier
	input  wire logic [7:0] rd_data_r,
	input  wire logic       rd_valid_r,
	input  wire logic       zone_valid_r
);
	logic [2:0] trusted_zone;

	// request lines idle at time zero
	initial
	begin
		rd_en = 1'b0;
		rd_addr = 8'h00;
		trusted_zone = 3'h0;
	end

	// one read: strobe for one cycle, then a bounded wait for the answer
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		int n;
		@(negedge clk_sys);
		rd_en = 1'b1;
		rd_addr = addr;
		@(negedge clk_sys);
		rd_en = 1'b0;
		rd_addr = ~addr; // released lines must not echo the last address
		n = 0;
		while (rd_valid_r !== 1'b1 && n < 4)
		begin
			@(negedge clk_sys);
			n++;
		end
		data = (n < 4) ? rd_data_r : 8'hXX;
		// zone is believed only while the input supply reads valid
		if (addr == 8'h02 && zone_valid_r === 1'b1)
			trusted_zone = data[2:0];
	endtask
endmodule // chgirq_host_model

// [verif/tb_chgirq_top.sv]
// tb_chgirq_top: self-checking bench for the charger interrupt flags and status block.
// assumes chgirq_host_model issues every register read; inputs move on falling edges.
`timescale 1ns/1ps

module tb_chgirq_top
	import chgirq_pkg::*;
;
	localparam int CVB = 3600;
	localparam int CVS = 25;
	localparam int SYB = 4100;
	localparam int SYS_S = 25;

	logic       clk_sys;
	logic       rst;
	logic       ok;
	logic       rd_en;
	logic [7:0] rd_addr;
	logic [7:0] rd_data_r;
	logic       rd_valid_r;
	logic [3:0] lp;
	logic [2:0] zone;
	logic [1:0] ist;
	logic [3:0] cst;
	logic [5:0] cv;
	logic [5:0] tcv;
	logic [4:0] sys;
	logic [5:0] cv_o;
	logic [5:0] tcv_o;
	logic       zv;
	int         fail_count;
	int         check_count;

	chgirq_top #(.CV_BASE_MV(CVB), .CV_STEP_MV(CVS), .SYS_BASE_MV(SYB), .SYS_STEP_MV(SYS_S))
	chgirq_top_i (.clk_sys(clk_sys), .rst(rst), .charger_input_ok(ok), .rd_en(rd_en),
		.rd_addr(rd_addr), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
		.input_voltage_loop_active(lp[3]), .input_current_loop_active(lp[2]),
		.system_voltage_loop_active(lp[1]), .die_temp_loop_active(lp[0]),
		.battery_temp_zone(zone), .input_supply_state(ist), .charger_state_code(cst),
		.cv_code_req(cv), .temp_cv_code_req(tcv), .sys_reg_code(sys),
		.charge_voltage_setting_r(cv_o), .temp_modified_charge_voltage_setting_r(tcv_o),
		.zone_valid_r(zv));

	chgirq_host_model host_i (.clk_sys(clk_sys), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .zone_valid_r(zv));

	// 20 MHz system clock
	always #25 clk_sys = ~clk_sys;

	// verdict and end of run, shared by the main sequence and the watchdog
	task automatic finish_test;
		$display("checks=%0d fails=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// byte compare
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// read a register and compare it
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host_i.read_reg(a, d);
		chk(d, exp);
	endtask

	// clearing read whose value is not judged
	task automatic flush;
		logic [7:0] d;
		host_i.read_reg(CHGIRQ_ADDR_FLAGS, d);
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// expected clamped code, worked out from the millivolt margin
	function automatic logic [5:0] exp_cv(input logic [5:0] r, input logic [4:0] s);
		int lim;
		lim = SYB + s * SYS_S - 200;
		if (CVB + r * CVS <= lim)
			return r;
		return (lim < CVB) ? 6'h00 : 6'((lim - CVB) / CVS);
	endfunction

	// reset values and an unmapped address
	task automatic t_reset;
		rdchk(CHGIRQ_ADDR_FLAGS, 8'h00);
		rdchk(CHGIRQ_ADDR_STATUS, 8'h00);
		rdchk(8'h05, 8'h00);
		$display("test reset done");
	endtask

	// each loop bit rising and falling; both edges raise its flag
	task automatic t_loops;
		int fb[4] = '{4, 4, 5, 3};
		for (int i = 0; i < 4; i++)
		begin
			flush;
			lp[3-i] = 1'b1;
			idle(5);
			rdchk(CHGIRQ_ADDR_STATUS, 8'h40 >> i);
			rdchk(CHGIRQ_ADDR_FLAGS, 8'h01 << fb[i]);
			lp[3-i] = 1'b0;
			idle(5);
			rdchk(CHGIRQ_ADDR_FLAGS, 8'h01 << fb[i]);
			rdchk(CHGIRQ_ADDR_FLAGS, 8'h00);
		end
		$display("test loops done");
	endtask

	// every zone code, ending back at zero
	task automatic t_zone;
		flush;
		for (int k = 1; k <= 6; k++)
		begin
			zone = 3'(k % 6);
			idle(5);
			rdchk(CHGIRQ_ADDR_STATUS, {5'h00, zone});
			rdchk(CHGIRQ_ADDR_FLAGS, 8'h01);
		end
		$display("test zone done");
	endtask

	// every input supply state and the zone qualifier
	task automatic t_input;
		flush;
		for (int k = 1; k <= 4; k++)
		begin
			ist = 2'(k % 4);
			idle(5);
			chk({7'h00, zv}, {7'h00, ist == 2'h3});
			rdchk(CHGIRQ_ADDR_FLAGS, 8'h04);
		end
		$display("test input done");
	endtask

	// charger state flag holds for a long idle, then one read clears it
	task automatic t_chg;
		flush;
		cst = 4'h9;
		idle(20);
		rdchk(CHGIRQ_ADDR_FLAGS, 8'h02);
		rdchk(CHGIRQ_ADDR_FLAGS, 8'h00);
		$display("test charger state done");
	endtask

	// clamp cases: system code, charge code, modified code, expected flags
	task automatic t_clamp;
		logic [4:0] cs[4] = '{5'h00, 5'h1F, 5'h00, 5'h00};
		logic [5:0] cc[4] = '{6'h14, 6'h0A, 6'h0C, 6'h0D};
		logic [5:0] ct[4] = '{6'h05, 6'h3F, 6'h0C, 6'h00};
		logic [7:0] cf[4] = '{8'h40, 8'h40, 8'h00, 8'h40};
		for (int i = 0; i < 4; i++)
		begin
			sys = cs[i];
			cv = cc[i];
			tcv = ct[i];
			idle(4);
			chk({2'h0, cv_o}, {2'h0, exp_cv(cv, sys)});
			chk({2'h0, tcv_o}, {2'h0, exp_cv(tcv, sys)});
			rdchk(CHGIRQ_ADDR_FLAGS, cf[i]);
			cv = 6'h00;
			tcv = 6'h00;
			idle(4);
			flush;
		end
		$display("test clamp done");
	endtask

	// change timed so its flag sets on the clearing read's own edge: the read misses it,
	// the flag must still be there for the next read
	task automatic t_coincide;
		logic [7:0] d1;
		logic [7:0] d2;
		flush;
		cst = cst + 4'h1;
		idle(1);
		host_i.read_reg(CHGIRQ_ADDR_FLAGS, d1);
		host_i.read_reg(CHGIRQ_ADDR_FLAGS, d2);
		chk(d1, 8'h00);
		chk(d2, 8'h02);
		$display("test coincide done");
	endtask

	// input loss clears status and fires change flags; the loss itself leaves the flags, a read or a reset clears them
	task automatic t_loss;
		flush;
		ist = 2'h3;
		zone = 3'h5;
		lp = 4'h8;
		idle(5);
		flush;
		ok = 1'b0;
		idle(5);
		rdchk(CHGIRQ_ADDR_STATUS, 8'h00);
		chk({7'h00, zv}, 8'h00);
		rdchk(CHGIRQ_ADDR_FLAGS, 8'h17);
		ist = 2'h0;
		zone = 3'h0;
		lp = 4'h0;
		cst = 4'h3;
		ok = 1'b1;
		idle(5);
		// a pending charger state flag must not survive a mid-run reset
		rst = 1'b1;
		idle(2);
		cst = 4'h0;
		rst = 1'b0;
		rdchk(CHGIRQ_ADDR_FLAGS, 8'h00);
		rdchk(CHGIRQ_ADDR_STATUS, 8'h00);
		$display("test loss done");
	endtask

	// watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		#1000000;
		fail_count++;
		finish_test;
	end

	// main sequence
	initial
	begin
		clk_sys = 1'b0;
		rst = 1'b1;
		ok = 1'b1;
		lp = 4'h0;
		zone = 3'h0;
		ist = 2'h0;
		cst = 4'h0;
		cv = 6'h00;
		tcv = 6'h00;
		sys = 5'h00;
		fail_count = 0;
		check_count = 0;
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		t_reset;
		t_loops;
		t_zone;
		t_input;
		t_chg;
		t_clamp;
		t_coincide;
		t_loss;
		finish_test;
	end
endmodule // tb_chgirq_top
